// >>> hdl/lcsp_pkg.sv
// Package for the LCD-shared port block: register indexes, field layouts,
// reset values and operating-mode codes.
// Assumes a 32-bit AHB-Lite register bus; byte address is four times the index.
package lcsp_pkg;

    // Register indexes (byte address = index * 4)
    localparam logic [15:0] LCSP_IDX_PORTA_LATCH = 16'hffdd;
    localparam logic [15:0] LCSP_IDX_PORTA_DIR = 16'hffed;
    localparam logic [15:0] LCSP_IDX_PORT8_LATCH = 16'hffdb;
    localparam logic [15:0] LCSP_IDX_PORT8_DIR = 16'hffeb;
    localparam logic [15:0] LCSP_IDX_LCD_CTRL = 16'hffc0;
    localparam logic [15:0] LCSP_IDX_MODE = 16'hffc1;

    // Reset values
    localparam logic [7:0] LCSP_PORTA_LATCH_RST = 8'hf0;
    localparam logic [7:0] LCSP_PORTA_DIR_RST = 8'hf0;
    localparam logic [7:0] LCSP_PORT8_RST = 8'h00;
    localparam logic [7:0] LCSP_LCD_CTRL_RST = 8'h00;
    localparam logic [7:0] LCSP_WO_READ = 8'hff;
    localparam logic [3:0] LCSP_PORTA_UNUSED = 4'hf;

    // LCD port control layout: segment select in [3:0], expansion select at bit 4
    localparam int LCSP_SEG_LSB = 0;
    localparam int LCSP_SEG_MSB = 3;
    localparam int LCSP_EXP_BIT = 4;

    // Operating mode field in [2:0]
    localparam logic [2:0] LCSP_MODE_ACTIVE = 3'h0;
    localparam logic [2:0] LCSP_MODE_SUBACTIVE = 3'h1;
    localparam logic [2:0] LCSP_MODE_SLEEP = 3'h2;
    localparam logic [2:0] LCSP_MODE_SUBSLEEP = 3'h3;
    localparam logic [2:0] LCSP_MODE_WATCH = 3'h4;
    localparam logic [2:0] LCSP_MODE_STANDBY = 3'h5;

    // Read back a port: latch where the pin is an output, pin level where input
    function automatic logic [6:0] lcsp_port_read(input logic [6:0] dir, input logic [6:0] latch,
                                                  input logic [6:0] pin);
        lcsp_port_read = (dir & latch) | (~dir & pin);
    endfunction : lcsp_port_read

    typedef enum logic [1:0] {LCSP_PH_IDLE, LCSP_PH_WRITE, LCSP_PH_READ1, LCSP_PH_READ2} lcsp_phase_t;

endpackage : lcsp_pkg

// >>> hdl/lcsp_ahb_slave.sv
// AHB-Lite slave front end for the LCD-shared port block.
// Writes complete with no wait state; reads insert one wait state so that
// the read data leave a flip-flop. Response is always OKAY.
`timescale 1ns/100ps
`default_nettype none
module lcsp_ahb_slave
    import lcsp_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Register side
    output logic [15:0] reg_idx,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);

    typedef struct packed {
        lcsp_phase_t phase;
        logic [15:0] idx;
        logic [7:0] rdata;
    } lcsp_slv_state_t;

    lcsp_slv_state_t state_reg;
    lcsp_slv_state_t state_next;
    logic take;

    ////////////////////////////////////////////////////////////////////////////
    assign hreadyout = (state_reg.phase != LCSP_PH_READ1);
    assign hresp = 1'b0;
    assign hrdata = {24'h0000_00, state_reg.rdata};
    assign reg_idx = state_reg.idx;
    assign reg_wr = (state_reg.phase == LCSP_PH_WRITE);
    assign reg_wdata = hwdata[7:0];
    // Only whole-word transfers are issued, so hsize is not decoded
    assign take = hsel && hready && htrans[1];

    always_comb begin
        state_next = state_reg;
        case (state_reg.phase)
            LCSP_PH_READ1: begin
                state_next.rdata = reg_rdata;
                state_next.phase = LCSP_PH_READ2;
            end
            default: begin
                state_next.phase = LCSP_PH_IDLE;
                if (take) begin
                    state_next.idx = haddr[17:2];
                    state_next.phase = hwrite ? LCSP_PH_WRITE : LCSP_PH_READ1;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : lcsp_ahb_slave
`default_nettype wire

// >>> hdl/lcsp_pin_mux.sv
// Function select for port 8 pins 6 to 0: general-purpose, LCD segment
// or LCD expansion output. Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module lcsp_pin_mux
    import lcsp_pkg::*;
(
    // Control
    input wire logic [3:0] seg_sel,
    input wire logic exp_sel,
    input wire logic [6:0] dir,
    input wire logic [6:0] latch,
    // LCD controller signals
    input wire logic [6:0] seg_out,
    input wire logic second_latch_clock,
    input wire logic expansion_data,
    input wire logic alt_drive,
    // Resulting pin drive
    output logic [6:0] pin_out,
    output logic [6:0] pin_drive
);

    logic gpio_sel;

    assign gpio_sel = (seg_sel[3:1] == 3'h0);

    always_comb begin
        pin_out = latch;
        pin_drive = dir;
        if (exp_sel) begin
            pin_out[6:4] = {second_latch_clock, expansion_data, alt_drive};
            pin_drive[6:4] = 3'h7;
        end else if (!gpio_sel) begin
            pin_out[6:4] = seg_out[6:4];
            pin_drive[6:4] = 3'h7;
        end
        // Otherwise pins 6..4 follow direction and latch as set above.
        if (!gpio_sel) begin
            pin_out[3:0] = seg_out[3:0];
            pin_drive[3:0] = 4'hf;
        end
    end

endmodule : lcsp_pin_mux
`default_nettype wire

// >>> hdl/lcsp_top.sv
// Port 8 (pins 6 to 0, shared with LCD segment and expansion outputs) and
// port A (4 pins) general-purpose I/O with AHB-Lite register access.
// Assumes LCD signals come from logic on hclk; pins come from outside and are
// synchronised. Output enables are active low.
//
// How it works
// - Segment 000x, no expansion: pins 6-4 GPIO
// - Otherwise, no expansion: pins 6-4 drive segments 31-29
// - Expansion set: pins 6-4 drive latch clock, data, alternation
// - Pins 3-0: GPIO or segment n+25
// - Port 8 Hi-Z in reset/standby, held when sleeping
// - Port A is four pins, upper bits read one
// - Port A read: latch for outputs, pin for inputs
// - Port A direction bit one means output
// - Port A settings act only with segment field 0000
// - Port A latch and direction reset to F0
// - Port A direction reads all ones
`timescale 1ns/100ps
`default_nettype none
module lcsp_top
    import lcsp_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // LCD controller signals
    input wire logic [6:0] segment_out_31_25,
    input wire logic second_latch_clock,
    input wire logic expansion_data,
    input wire logic alt_drive,
    // Port 8 pins 6..0
    input wire logic [6:0] port8_pin_in,
    output logic [6:0] port8_pin_out,
    output logic [6:0] port8_pin_oe_n,
    // Port A pins 3..0
    input wire logic [3:0] porta_pin_in,
    output logic [3:0] porta_pin_out,
    output logic [3:0] porta_pin_oe_n
);

    typedef struct packed {
        logic [3:0] porta_output_latch;
        logic [3:0] porta_direction_reg;
        logic [6:0] port8_latch;
        logic [6:0] port8_direction_reg;
        logic [3:0] segment_select_field;
        logic lcd_expansion_select;
        logic [2:0] mode;
        logic [6:0] p8_sync1;
        logic [6:0] p8_sync2;
        logic [3:0] pa_sync1;
        logic [3:0] pa_sync2;
        logic [6:0] p8_out;
        logic [6:0] p8_oe_n;
        logic [3:0] pa_out;
        logic [3:0] pa_oe_n;
    } lcsp_state_t;

    lcsp_state_t state_reg;
    lcsp_state_t state_next;

    logic [15:0] reg_idx;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [6:0] mux_out;
    logic [6:0] mux_drive;
    logic gpio_sel;
    logic pins_float;
    logic pins_hold;
    logic [6:0] pa_read;

    ////////////////////////////////////////////////////////////////////////////
    // Bus front end

    lcsp_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .reg_idx(reg_idx),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port 8 function select

    lcsp_pin_mux u_mux (
        .seg_sel(state_reg.segment_select_field),
        .exp_sel(state_reg.lcd_expansion_select),
        .dir(state_reg.port8_direction_reg),
        .latch(state_reg.port8_latch),
        .seg_out(segment_out_31_25),
        .second_latch_clock(second_latch_clock),
        .expansion_data(expansion_data),
        .alt_drive(alt_drive),
        .pin_out(mux_out),
        .pin_drive(mux_drive)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Port A pins are general-purpose only with the whole segment field clear
    assign gpio_sel = (state_reg.segment_select_field == 4'h0);

    // Port A read-back, widened to the shared seven-bit helper
    assign pa_read = lcsp_port_read({3'h0, state_reg.porta_direction_reg}, {3'h0, state_reg.porta_output_latch},
                                    {3'h0, state_reg.pa_sync2});

    always_comb begin
        reg_rdata = 8'h00;
        case (reg_idx)
            LCSP_IDX_PORTA_LATCH: begin
                reg_rdata = {LCSP_PORTA_UNUSED, pa_read[3:0]};
            end
            LCSP_IDX_PORTA_DIR: begin
                reg_rdata = LCSP_WO_READ;
            end
            LCSP_IDX_PORT8_LATCH: begin
                reg_rdata = {1'b0, lcsp_port_read(state_reg.port8_direction_reg, state_reg.port8_latch,
                             state_reg.p8_sync2)};
            end
            LCSP_IDX_PORT8_DIR: begin
                reg_rdata = LCSP_WO_READ;
            end
            LCSP_IDX_LCD_CTRL: begin
                reg_rdata = {3'h0, state_reg.lcd_expansion_select, state_reg.segment_select_field};
            end
            LCSP_IDX_MODE: begin
                reg_rdata = {5'h00, state_reg.mode};
            end
            default: begin
                reg_rdata = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    assign pins_float = (state_reg.mode == LCSP_MODE_STANDBY);
    assign pins_hold = (state_reg.mode == LCSP_MODE_SLEEP) || (state_reg.mode == LCSP_MODE_SUBSLEEP)
                       || (state_reg.mode == LCSP_MODE_WATCH);

    always_comb begin
        state_next = state_reg;
        // Two-flop synchronisers on the pin inputs
        state_next.p8_sync1 = port8_pin_in;
        state_next.p8_sync2 = state_reg.p8_sync1;
        state_next.pa_sync1 = porta_pin_in;
        state_next.pa_sync2 = state_reg.pa_sync1;

        if (reg_wr) begin
            case (reg_idx)
                LCSP_IDX_PORTA_LATCH: begin
                    state_next.porta_output_latch = reg_wdata[3:0];
                end
                LCSP_IDX_PORTA_DIR: begin
                    state_next.porta_direction_reg = reg_wdata[3:0];
                end
                LCSP_IDX_PORT8_LATCH: begin
                    state_next.port8_latch = reg_wdata[6:0];
                end
                LCSP_IDX_PORT8_DIR: begin
                    state_next.port8_direction_reg = reg_wdata[6:0];
                end
                LCSP_IDX_LCD_CTRL: begin
                    state_next.segment_select_field = reg_wdata[LCSP_SEG_MSB:LCSP_SEG_LSB];
                    state_next.lcd_expansion_select = reg_wdata[LCSP_EXP_BIT];
                end
                LCSP_IDX_MODE: begin
                    state_next.mode = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // Port 8 pin drive; sleeping modes freeze the last drive so the panel
        // keeps its picture without the LCD logic running
        if (pins_float) begin
            state_next.p8_oe_n = 7'h7f;
        end else if (!pins_hold) begin
            state_next.p8_out = mux_out;
            state_next.p8_oe_n = ~mux_drive;
        end

        // Port A drive; released while the LCD side owns the pins
        if (gpio_sel) begin
            state_next.pa_out = state_reg.porta_output_latch;
            state_next.pa_oe_n = ~state_reg.porta_direction_reg;
        end else begin
            state_next.pa_oe_n = 4'hf;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
            state_reg.porta_output_latch <= LCSP_PORTA_LATCH_RST[3:0];
            state_reg.porta_direction_reg <= LCSP_PORTA_DIR_RST[3:0];
            state_reg.port8_latch <= LCSP_PORT8_RST[6:0];
            state_reg.port8_direction_reg <= LCSP_PORT8_RST[6:0];
            state_reg.segment_select_field <= LCSP_LCD_CTRL_RST[3:0];
            state_reg.mode <= LCSP_MODE_ACTIVE;
            state_reg.p8_oe_n <= 7'h7f;
            state_reg.pa_oe_n <= 4'hf;
        end else begin
            state_reg <= state_next;
        end
    end

    assign port8_pin_out = state_reg.p8_out;
    assign port8_pin_oe_n = state_reg.p8_oe_n;
    assign porta_pin_out = state_reg.pa_out;
    assign porta_pin_oe_n = state_reg.pa_oe_n;

endmodule : lcsp_top
`default_nettype wire

// >>> tb/lcsp_props.sv
// Checker for the LCD-shared port block: pin function per mode and control.
// Assumes hready is hreadyout; shadows register writes seen on the bus.
`timescale 1ns/100ps
`default_nettype none
module lcsp_props
    import lcsp_pkg::*;
(
    // Bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    // LCD signals and pins
    input wire logic [6:0] segment_out_31_25,
    input wire logic second_latch_clock,
    input wire logic expansion_data,
    input wire logic alt_drive,
    input wire logic [6:0] port8_pin_out,
    input wire logic [6:0] port8_pin_oe_n,
    input wire logic [3:0] porta_pin_oe_n
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
logic wp;
logic [15:0] wi;
logic [7:0] ctl, md, d8, l8, da;
logic act, ex, sg, gl, gh, sl, sb, pg;
logic [6:0] d7, l7;
logic [3:0] da4;
logic [2:0] lcd;
// Sleep-like modes freeze the pins, standby floats them
assign act = !(md[2:0] inside {LCSP_MODE_SLEEP, LCSP_MODE_SUBSLEEP, LCSP_MODE_WATCH, LCSP_MODE_STANDBY});
assign sb = md[2:0] == LCSP_MODE_STANDBY;
assign sl = !act && !sb;
assign ex = ctl[4] && act;
assign gl = ctl[3:1] == 3'h0 && act;
assign gh = gl && !ctl[4];
assign sg = !ctl[4] && ctl[3:1] != 3'h0 && act;
assign pg = ctl[3:0] == 4'h0;
assign d7 = d8[6:0];
assign l7 = l8[6:0];
assign da4 = da[3:0];
assign lcd = {second_latch_clock, expansion_data, alt_drive};
////////////////////////////////////////////////////////////////////////
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wp <= 1'b0;
        wi <= 16'h0000;
        ctl <= LCSP_LCD_CTRL_RST;
        md <= 8'h00;
        d8 <= LCSP_PORT8_RST;
        l8 <= LCSP_PORT8_RST;
        da <= LCSP_PORTA_DIR_RST;
    end else if (hready) begin
        wp <= hsel && htrans[1] && hwrite;
        wi <= haddr[17:2];
        if (wp) begin
            case (wi)
                LCSP_IDX_LCD_CTRL: ctl <= hwdata[7:0];
                LCSP_IDX_MODE: md <= hwdata[7:0];
                LCSP_IDX_PORT8_DIR: d8 <= hwdata[7:0];
                LCSP_IDX_PORT8_LATCH: l8 <= hwdata[7:0];
                LCSP_IDX_PORTA_DIR: da <= hwdata[7:0];
                default: ;
            endcase
        end
    end
end
////////////////////////////////////////////////////////////////////////
reset_hiz_a: assert property ($rose(hresetn) |-> port8_pin_oe_n == 7'h7f && porta_pin_oe_n == 4'hf)
    else $error("pins driven after reset");
exp_pins_a: assert property ($past(ex) |-> port8_pin_oe_n[6:4] == 3'h0 && port8_pin_out[6:4] == $past(lcd))
    else $error("expansion pins wrong");
seg_pins_a: assert property ($past(sg) |-> port8_pin_oe_n == 7'h00 && port8_pin_out == $past(segment_out_31_25))
    else $error("segment pins wrong");
gpio_low_a: assert property ($past(gl) |-> ((port8_pin_oe_n ^ ~$past(d7)) & 7'h0f) == 7'h00
    && ((port8_pin_out ^ $past(l7)) & $past(d7) & 7'h0f) == 7'h00) else $error("pins 3-0 wrong");
gpio_high_a: assert property ($past(gh) |-> ((port8_pin_oe_n ^ ~$past(d7)) & 7'h70) == 7'h00)
    else $error("pins 6-4 direction wrong");
sleep_hold_a: assert property ($past(sl) |-> $stable(port8_pin_out) && $stable(port8_pin_oe_n))
    else $error("port 8 moved while asleep");
standby_hiz_a: assert property ($past(sb) |-> port8_pin_oe_n == 7'h7f)
    else $error("port 8 driven in standby");
porta_dir_a: assert property ($past(pg) |-> porta_pin_oe_n == ~$past(da4))
    else $error("port A direction wrong");
porta_off_a: assert property ($past(pg) == 1'b0 |-> porta_pin_oe_n == 4'hf)
    else $error("port A driven under LCD use");
read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule : lcsp_props
bind lcsp_top lcsp_props lcsp_props_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .segment_out_31_25, .second_latch_clock, .expansion_data, .alt_drive, .port8_pin_out,
    .port8_pin_oe_n, .porta_pin_oe_n);
`default_nettype wire

// >>> tb/lcsp_pin_model.sv
// Outside world at the package pins: a driven pin shows the block's value.
// Assumes no pull resistors; a released pin takes the level the bench offers.
`timescale 1ns/100ps
`default_nettype none
module lcsp_pin_model (
    // Outside levels
    input wire logic [6:0] ext8,
    input wire logic [3:0] exta,
    // Block drive
    input wire logic [6:0] out8,
    input wire logic [6:0] oe8_n,
    input wire logic [3:0] outa,
    input wire logic [3:0] oea_n,
    // Resolved levels
    output logic [6:0] pin8,
    output logic [3:0] pina
);
assign pin8 = (out8 & ~oe8_n) | (ext8 & oe8_n);
assign pina = (outa & ~oea_n) | (exta & oea_n);
endmodule : lcsp_pin_model
`default_nettype wire

// >>> tb/lcsp_top_tb.sv
// Testbench for the LCD-shared port block over AHB-Lite.
// Assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
`default_nettype none
module lcsp_top_tb import lcsp_pkg::*;;
logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
logic [31:0] haddr, hwdata, hrdata;
logic [1:0] htrans;
logic [6:0] seg, ext8, pin8, out8, oe8;
logic [3:0] exta, pina, outa, oea;
logic [2:0] lcd;
logic [7:0] rd;
int n_fail, num_checks;
lcsp_top lcsp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .segment_out_31_25(seg), .second_latch_clock(lcd[2]),
    .expansion_data(lcd[1]), .alt_drive(lcd[0]), .port8_pin_in(pin8), .port8_pin_out(out8),
    .port8_pin_oe_n(oe8), .porta_pin_in(pina), .porta_pin_out(outa), .porta_pin_oe_n(oea));
lcsp_pin_model lcsp_pin_model_inst (.ext8(ext8), .exta(exta), .out8(out8), .oe8_n(oe8), .outa(outa),
    .oea_n(oea), .pin8(pin8), .pina(pina));
always #20 hclk = ~hclk;
////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
        n_fail++;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
endtask : chk
task automatic xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata[7:0];
endtask : xfer
task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
endtask : settle
task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask : report_and_stop
////////////////////////////////////////////////////////////////////////
task automatic t_porta();
    xfer(LCSP_IDX_PORTA_LATCH, 1'b0, 8'h00, rd);
    chk("porta_latch", rd, 8'hf5);
    chk("porta_width", rd[7:4], 4'hf);
    xfer(LCSP_IDX_PORTA_DIR, 1'b1, 8'h0c, rd);
    xfer(LCSP_IDX_PORTA_LATCH, 1'b0, 8'h00, rd);
    chk("porta_rst_latch", rd, 8'hf1);
    xfer(LCSP_IDX_PORTA_LATCH, 1'b1, 8'h5a, rd);
    xfer(LCSP_IDX_PORTA_LATCH, 1'b0, 8'h00, rd);
    chk("porta_mix", rd, 8'hf9);
    chk("porta_upper", rd[7:4], 4'hf);
    settle(2);
    chk("porta_oe", oea, 4'h3);
    chk("porta_out", outa & 4'hc, 4'h8);
    xfer(LCSP_IDX_LCD_CTRL, 1'b1, 8'h01, rd);
    settle(2);
    chk("porta_off", oea, 4'hf);
    xfer(LCSP_IDX_PORTA_DIR, 1'b0, 8'h00, rd);
    chk("porta_dir", rd, 8'hff);
endtask : t_porta
task automatic t_port8();
    xfer(LCSP_IDX_PORT8_DIR, 1'b1, 8'h5a, rd);
    xfer(LCSP_IDX_PORT8_LATCH, 1'b1, 8'h3c, rd);
    settle(3);
    chk("p8_oe", oe8, 7'h25);
    chk("p8_out", out8 & 7'h5a, 7'h18);
    xfer(LCSP_IDX_PORT8_LATCH, 1'b0, 8'h00, rd);
    chk("p8_read", rd, 8'h39);
endtask : t_port8
task automatic t_lcd();
    logic [7:0] sv [4] = '{8'h02, 8'h04, 8'h08, 8'h0f};
    for (int i = 0; i < 4; i++) begin
        @(posedge hclk);
        seg <= 7'h2b + 7'(i);
        xfer(LCSP_IDX_LCD_CTRL, 1'b1, sv[i], rd);
        settle(2);
        chk("seg_oe", oe8, 7'h00);
        chk("seg_out", out8, 7'h2b + 7'(i));
    end
    xfer(LCSP_IDX_LCD_CTRL, 1'b1, 8'h1f, rd);
    settle(2);
    chk("exp_seg", out8, {3'h5, 4'he});
    xfer(LCSP_IDX_LCD_CTRL, 1'b1, 8'h10, rd);
    settle(2);
    chk("exp_gpio_oe", oe8, 7'h05);
    chk("exp_gpio_out", out8 & 7'h7a, 7'h58);
endtask : t_lcd
task automatic t_modes();
    xfer(LCSP_IDX_LCD_CTRL, 1'b1, 8'h01, rd);
    xfer(LCSP_IDX_MODE, 1'b1, {5'h00, LCSP_MODE_STANDBY}, rd);
    settle(2);
    chk("standby_oe", oe8, 7'h7f);
    for (logic [2:0] m = LCSP_MODE_SLEEP; m <= LCSP_MODE_WATCH; m++) begin
        xfer(LCSP_IDX_MODE, 1'b1, {5'h00, LCSP_MODE_SUBACTIVE}, rd);
        xfer(LCSP_IDX_PORT8_LATCH, 1'b1, 8'h3c, rd);
        xfer(LCSP_IDX_MODE, 1'b1, {5'h00, m}, rd);
        xfer(LCSP_IDX_PORT8_LATCH, 1'b1, 8'h42, rd);
        settle(2);
        chk("held_out", out8 & 7'h5a, 7'h18);
        chk("held_oe", oe8, 7'h25);
        xfer(LCSP_IDX_MODE, 1'b1, {5'h00, LCSP_MODE_SUBACTIVE}, rd);
        settle(2);
        chk("wake_out", out8 & 7'h5a, 7'h42);
    end
endtask : t_modes
////////////////////////////////////////////////////////////////////////
initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    seg = 7'h00;
    lcd = 3'h5;
    ext8 = 7'h21;
    exta = 4'h5;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    settle(3);
    chk("reset_oe", {oe8, oea}, 11'h7ff);
    t_porta();
    t_port8();
    t_lcd();
    t_modes();
    report_and_stop();
end
// Whole run needs well under a thousand cycles
initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    report_and_stop();
end
endmodule : lcsp_top_tb
`default_nettype wire
